// ===== hdl/pcwl_pkg.sv
`default_nettype none
package pcwl_pkg;
  // Store word addresses
  localparam logic [7:0] WA_P3  = 8'h66;
  localparam logic [7:0] WA_PB0 = 8'h70;
  localparam logic [7:0] WA_PB3 = 8'h76;
  localparam logic [7:0] WA_PM0 = 8'h80;
  localparam logic [7:0] WA_PM1 = 8'h82;
  localparam int NUM_WORDS = 7;
  // Per-port configuration offsets
  localparam logic [9:0] OFF_SLOT = 10'h0c0;
  localparam logic [9:0] OFF_CLK  = 10'h0d0;
  localparam logic [9:0] OFF_DSI  = 10'h040;
  localparam logic [9:0] OFF_LOVC = 10'h144;
  localparam logic [9:0] OFF_PNUM = 10'h0cc;
  localparam logic [9:0] OFF_TC   = 10'h154;
  localparam logic [9:0] OFF_PB   = 10'h214;
  localparam logic [9:0] OFF_PBA  = 10'h218;
  localparam logic [9:0] OFF_PMC  = 10'h074;
  localparam logic [9:0] OFF_VGA  = 10'h070;
  localparam logic [9:0] OFF_VEN  = 10'h088;
  // Source bits in the word, and field widths
  localparam int S_SLOT = 0;
  localparam int S_CLK = 1;
  localparam int S_DSI = 2;
  localparam int S_LOVC = 3;
  localparam int S_PNUM = 4;
  localparam int W_PNUM = 3;
  localparam int S_TC = 9;
  localparam int W_TC = 7;
  localparam int S_BASE = 0;
  localparam int W_BASE = 8;
  localparam int S_SCALE = 8;
  localparam int S_PMST = 10;
  localparam int S_SYS = 15;
  localparam int S_PMC = 0;
  localparam int W_PMC = 6;
  localparam int S_RXP = 6;
  localparam int S_VGA = 7;
  localparam int S_VEN = 8;
  localparam int W_VEN = 8;
  // Destination bits in the configuration dword
  localparam int D_SLOT = 24;
  localparam int D_CLK = 28;
  localparam int D_DSI = 21;
  localparam int D_LOVC = 4;
  localparam int D_PNUM = 24;
  localparam int D_TC = 1;
  localparam int D_SCALE = 8;
  localparam int D_PMST = 13;
  localparam int D_PMC = 8;
  localparam int D_RXP = 14;
  localparam int D_VGA = 31;
  localparam int D_VEN = 24;
  // Local registers
  localparam int ADDR_W = 13;
  localparam int LOC_BIT = 12;
  localparam logic [12:0] LOC_STATUS = 13'h1000;
  localparam logic [12:0] LOC_CTRL = 13'h1004;
  localparam int CTRL_RELOAD = 0;
  localparam int ST_DONE = 0;
  localparam int ST_MASK = 16;
  // Word kinds
  typedef enum logic [1:0] {
    KIND_NONE, KIND_P3, KIND_PB, KIND_PM
  } pcwl_kind_t;
endpackage
`default_nettype wire

// ===== hdl/pcwl_word_decode.sv
`default_nettype none
module pcwl_word_decode (
  // Store word address
  input  wire logic [7:0]        addr,
  // Decoded target
  output logic                   hit,
  output pcwl_pkg::pcwl_kind_t   kind,
  output logic [1:0]             port,
  output logic [2:0]             idx
);
  logic       is_p3;
  logic       is_pb;
  logic       is_pm;
  logic [7:0] pb_off;

  // Word kind by address; odd addresses never hit
  assign is_p3 = addr == pcwl_pkg::WA_P3;
  assign is_pb = addr >= pcwl_pkg::WA_PB0 && addr <= pcwl_pkg::WA_PB3
                 && !addr[0];
  assign is_pm = addr == pcwl_pkg::WA_PM0 || addr == pcwl_pkg::WA_PM1;
  assign pb_off = addr - pcwl_pkg::WA_PB0;
  assign hit = is_p3 | is_pb | is_pm;
  assign kind = is_p3 ? pcwl_pkg::KIND_P3 :
                is_pb ? pcwl_pkg::KIND_PB :
                is_pm ? pcwl_pkg::KIND_PM : pcwl_pkg::KIND_NONE;
  // Consecutive words step one port each
  assign port = is_p3 ? 2'h3 : is_pb ? pb_off[2:1] : {1'b0, addr[1]};
  assign idx = is_p3 ? 3'h0 :
               is_pb ? 3'h1 + {1'b0, pb_off[2:1]} :
               3'h5 + {2'b00, addr[1]};
endmodule // pcwl_word_decode
`default_nettype wire

// ===== hdl/pcwl_port_bank.sv
`default_nettype none
module pcwl_port_bank (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Load strobes and word
  input  wire logic        ld_p3,
  input  wire logic        ld_pb,
  input  wire logic        ld_pm,
  input  wire logic [15:0] word,
  // Port-3 word fields
  output logic             slot_impl,
  output logic             ref_clk_conn,
  output logic             dsi_req,
  output logic             low_priority_vc_count,
  output logic [2:0]       port_num,
  output logic [6:0]       tc_map,
  // Power budget fields
  output logic [7:0]       pb_base,
  output logic [1:0]       pb_scale,
  output logic [1:0]       pb_pmst,
  output logic             pb_sys,
  // Power management word fields
  output logic [5:0]       pm_ctl,
  output logic             rx_pol_dis,
  output logic             vga_en,
  output logic [7:0]       vendor_phy_control_five
);
  // Slot, clock, init, vc and port number fields
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      slot_impl <= 1'b0;
      ref_clk_conn <= 1'b0;
      dsi_req <= 1'b0;
      low_priority_vc_count <= 1'b0;
      port_num <= 3'h0;
      tc_map <= 7'h00;
    end else if (ld_p3) begin
      slot_impl <= word[pcwl_pkg::S_SLOT];
      ref_clk_conn <= word[pcwl_pkg::S_CLK];
      dsi_req <= word[pcwl_pkg::S_DSI];
      low_priority_vc_count <= word[pcwl_pkg::S_LOVC];
      port_num <= word[pcwl_pkg::S_PNUM +: pcwl_pkg::W_PNUM];
      tc_map <= word[pcwl_pkg::S_TC +: pcwl_pkg::W_TC];
    end
  end

  // Power budget fields
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pb_base <= 8'h00;
      pb_scale <= 2'h0;
      pb_pmst <= 2'h0;
      pb_sys <= 1'b0;
    end else if (ld_pb) begin
      pb_base <= word[pcwl_pkg::S_BASE +: pcwl_pkg::W_BASE];
      pb_scale <= word[pcwl_pkg::S_SCALE +: 2];
      pb_pmst <= word[pcwl_pkg::S_PMST +: 2];
      pb_sys <= word[pcwl_pkg::S_SYS];
    end
  end

  // Power management, vga and vendor fields
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pm_ctl <= 6'h00;
      rx_pol_dis <= 1'b0;
      vga_en <= 1'b0;
      vendor_phy_control_five <= 8'h00;
    end else if (ld_pm) begin
      pm_ctl <= word[pcwl_pkg::S_PMC +: pcwl_pkg::W_PMC];
      rx_pol_dis <= word[pcwl_pkg::S_RXP];
      vga_en <= word[pcwl_pkg::S_VGA];
      vendor_phy_control_five <=
        word[pcwl_pkg::S_VEN +: pcwl_pkg::W_VEN];
    end
  end
endmodule // pcwl_port_bank
`default_nettype wire

// ===== hdl/pcwl_loader.sv
// How it works
// - Port-3 word 66h bit 0 goes to offset C0h bit 24.
// - Port-3 word bit 1 goes to offset D0h bit 28.
// - Port-3 word bit 2 goes to offset 40h bit 21.
// - Port-3 word bit 3 goes to offset 144h bit 4.
// - Port-3 word bits 6:4 go to offset CCh bits 26:24.
// - Port-3 word bits 15:9 go to offset 154h bits 7:1.
// - Budget words 70h..76h target ports 0..3, offsets 214h and 218h.
// - Budget bits 9:0 land at the same positions of 214h.
// - Budget bits 11:10 go to 214h bits 14:13.
// - Budget bit 15 goes to 218h bit 0.
// - PM word 80h/82h bits 5:0 go to 74h bits 13:8.
// - PM word bit 6 goes to 74h bit 14.
// - PM word bit 7 goes to 70h bit 31.
// - PM word bits 15:8 go to 88h bits 31:24.
//
// The plain strobed port and the register addresses are this design's own decisions.
`default_nettype none
module pcwl_loader (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Word stream from the configuration store
  input  wire logic        ld_valid,
  input  wire logic [7:0]  ld_addr,
  input  wire logic [15:0] ld_data,
  input  wire logic        ld_last,
  // Register port
  input  wire logic [12:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Load status
  output logic             load_done
);
  localparam int NP = 4;

  // Loader state
  logic                           done_r;
  logic                           done_nxt;
  logic [pcwl_pkg::NUM_WORDS-1:0] applied_r;
  logic [pcwl_pkg::NUM_WORDS-1:0] applied_nxt;
  logic [31:0]                    rdata_r;
  logic [31:0]                    rdata_nxt;

  // Decoded word target
  logic                           dec_hit;
  pcwl_pkg::pcwl_kind_t           dec_kind;
  logic [1:0]                     dec_port;
  logic [2:0]                     dec_idx;
  logic [pcwl_pkg::NUM_WORDS-1:0] dec_onehot;
  logic                           take;
  logic                           apply;
  logic                           reload;

  // Per-port field outputs
  logic       slot_impl   [NP];
  logic       ref_clk_conn[NP];
  logic       dsi_req     [NP];
  logic       lo_vc_cnt   [NP];
  logic [2:0] port_num    [NP];
  logic [6:0] tc_map      [NP];
  logic [7:0] pb_base     [NP];
  logic [1:0] pb_scale    [NP];
  logic [1:0] pb_pmst     [NP];
  logic       pb_sys      [NP];
  logic [5:0] pm_ctl      [NP];
  logic       rx_pol_dis  [NP];
  logic       vga_en      [NP];
  logic [7:0] vendor_five [NP];

  pcwl_word_decode u_dec (
    .addr (ld_addr),
    .hit  (dec_hit),
    .kind (dec_kind),
    .port (dec_port),
    .idx  (dec_idx)
  );

  // Words are taken only while loading is open
  assign take = ld_valid & ~done_r;
  // A word already applied is ignored until reload
  assign apply = take & dec_hit & ~applied_r[dec_idx];
  assign dec_onehot = {{(pcwl_pkg::NUM_WORDS-1){1'b0}}, 1'b1} << dec_idx;
  assign reload = reg_wr & reg_addr == pcwl_pkg::LOC_CTRL
                  & reg_wdata[pcwl_pkg::CTRL_RELOAD];

  // One bank per port; strobes route each word to its port
  for (genvar p = 0; p < NP; p++) begin : g_port
    logic ld_p3;
    logic ld_pb;
    logic ld_pm;
    logic hit_port;

    assign hit_port = apply & dec_port == 2'(p);
    assign ld_p3 = hit_port & dec_kind == pcwl_pkg::KIND_P3;
    assign ld_pb = hit_port & dec_kind == pcwl_pkg::KIND_PB;
    assign ld_pm = hit_port & dec_kind == pcwl_pkg::KIND_PM;

    pcwl_port_bank u_bank (
      .ref_clk                 (ref_clk),
      .sys_rst                 (sys_rst),
      .ld_p3                   (ld_p3),
      .ld_pb                   (ld_pb),
      .ld_pm                   (ld_pm),
      .word                    (ld_data),
      .slot_impl               (slot_impl[p]),
      .ref_clk_conn            (ref_clk_conn[p]),
      .dsi_req                 (dsi_req[p]),
      .low_priority_vc_count   (lo_vc_cnt[p]),
      .port_num                (port_num[p]),
      .tc_map                  (tc_map[p]),
      .pb_base                 (pb_base[p]),
      .pb_scale                (pb_scale[p]),
      .pb_pmst                 (pb_pmst[p]),
      .pb_sys                  (pb_sys[p]),
      .pm_ctl                  (pm_ctl[p]),
      .rx_pol_dis              (rx_pol_dis[p]),
      .vga_en                  (vga_en[p]),
      .vendor_phy_control_five (vendor_five[p])
    );
  end

  // Load bookkeeping; a set wins over a reload clear
  assign applied_nxt = (reload ? '0 : applied_r)
                       | (apply ? dec_onehot : '0);
  assign done_nxt = (done_r & ~reload) | (take & ld_last);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      done_r <= 1'b0;
      applied_r <= '0;
    end else begin
      done_r <= done_nxt;
      applied_r <= applied_nxt;
    end
  end

  // Read side: port from upper address bits, dword by offset
  logic [1:0]  rd_port;
  logic [9:0]  rd_off;
  logic        rd_loc;
  logic [31:0] dw_slot;
  logic [31:0] dw_clk;
  logic [31:0] dw_dsi;
  logic [31:0] dw_lovc;
  logic [31:0] dw_pnum;
  logic [31:0] dw_tc;
  logic [31:0] dw_pb;
  logic [31:0] dw_pba;
  logic [31:0] dw_pmc;
  logic [31:0] dw_vga;
  logic [31:0] dw_ven;
  logic [31:0] dw_cfg;
  logic [31:0] dw_status;
  logic [31:0] dw_loc;

  assign rd_port = reg_addr[11:10];
  assign rd_off = reg_addr[9:0];
  assign rd_loc = reg_addr[pcwl_pkg::LOC_BIT];

  // Field placement; unmapped bits read their reset zero
  assign dw_slot = 32'(slot_impl[rd_port]) << pcwl_pkg::D_SLOT;
  assign dw_clk = 32'(ref_clk_conn[rd_port]) << pcwl_pkg::D_CLK;
  assign dw_dsi = 32'(dsi_req[rd_port]) << pcwl_pkg::D_DSI;
  assign dw_lovc = 32'(lo_vc_cnt[rd_port]) << pcwl_pkg::D_LOVC;
  assign dw_pnum = 32'(port_num[rd_port]) << pcwl_pkg::D_PNUM;
  assign dw_tc = 32'(tc_map[rd_port]) << pcwl_pkg::D_TC;
  assign dw_pb = 32'(pb_base[rd_port])
                 | (32'(pb_scale[rd_port]) << pcwl_pkg::D_SCALE)
                 | (32'(pb_pmst[rd_port]) << pcwl_pkg::D_PMST);
  assign dw_pba = 32'(pb_sys[rd_port]);
  assign dw_pmc = (32'(pm_ctl[rd_port]) << pcwl_pkg::D_PMC)
                  | (32'(rx_pol_dis[rd_port]) << pcwl_pkg::D_RXP);
  assign dw_vga = 32'(vga_en[rd_port]) << pcwl_pkg::D_VGA;
  assign dw_ven = 32'(vendor_five[rd_port]) << pcwl_pkg::D_VEN;

  // Offset select; anything else reads zero
  assign dw_cfg = rd_off == pcwl_pkg::OFF_SLOT ? dw_slot :
                  rd_off == pcwl_pkg::OFF_CLK  ? dw_clk  :
                  rd_off == pcwl_pkg::OFF_DSI  ? dw_dsi  :
                  rd_off == pcwl_pkg::OFF_LOVC ? dw_lovc :
                  rd_off == pcwl_pkg::OFF_PNUM ? dw_pnum :
                  rd_off == pcwl_pkg::OFF_TC   ? dw_tc   :
                  rd_off == pcwl_pkg::OFF_PB   ? dw_pb   :
                  rd_off == pcwl_pkg::OFF_PBA  ? dw_pba  :
                  rd_off == pcwl_pkg::OFF_PMC  ? dw_pmc  :
                  rd_off == pcwl_pkg::OFF_VGA  ? dw_vga  :
                  rd_off == pcwl_pkg::OFF_VEN  ? dw_ven  : '0;

  assign dw_status = (32'(done_r) << pcwl_pkg::ST_DONE)
                     | (32'(applied_r) << pcwl_pkg::ST_MASK);
  // Reload bit is a pulse, so control reads zero
  assign dw_loc = reg_addr == pcwl_pkg::LOC_STATUS ? dw_status : '0;

  // Config reads stay zero until the load has finished
  assign rdata_nxt = !reg_rd ? '0 :
                     rd_loc  ? dw_loc :
                     done_r  ? dw_cfg : '0;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign load_done = done_r;

  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_p3_word;
    apply && dec_kind == pcwl_pkg::KIND_P3;
  endsequence

  sequence s_pb2_word;
    apply && dec_kind == pcwl_pkg::KIND_PB && dec_port == 2'h2;
  endsequence

  sequence s_pm1_word;
    apply && dec_kind == pcwl_pkg::KIND_PM && dec_port == 2'h1;
  endsequence

  sequence s_early_cfg_read;
    reg_rd && !done_r && !rd_loc;
  endsequence

  chk_slot_impl_copy: assert property (
    s_p3_word |=> slot_impl[3] == $past(ld_data[0]))
    else $error("slot implemented bit not loaded");
  chk_ref_clock_copy: assert property (
    s_p3_word |=> ref_clk_conn[3] == $past(ld_data[1]))
    else $error("slot clock bit not loaded");
  chk_dsi_copy: assert property (
    s_p3_word |=> dsi_req[3] == $past(ld_data[2]))
    else $error("init required bit not loaded");
  chk_low_vc_copy: assert property (
    s_p3_word |=> lo_vc_cnt[3] == $past(ld_data[3]))
    else $error("low priority vc bit not loaded");
  chk_port_num_copy: assert property (
    s_p3_word |=> port_num[3] == $past(ld_data[6:4]))
    else $error("port number not loaded");
  chk_tc_map_copy: assert property (
    s_p3_word |=> tc_map[3] == $past(ld_data[15:9]))
    else $error("tc map not loaded");
  chk_pb_route_port: assert property (
    apply && ld_addr == pcwl_pkg::WA_PB3
    |=> pb_base[3] == $past(ld_data[7:0]) && $stable(pb_base[0]))
    else $error("budget word reached wrong port");
  chk_pb_base_scale: assert property (
    s_pb2_word |=> pb_base[2] == $past(ld_data[7:0])
                   && pb_scale[2] == $past(ld_data[9:8]))
    else $error("base power or scale not loaded");
  chk_pb_pm_state: assert property (
    s_pb2_word |=> pb_pmst[2] == $past(ld_data[11:10]))
    else $error("budget pm state not loaded");
  chk_pb_sys_alloc: assert property (
    s_pb2_word |=> pb_sys[2] == $past(ld_data[15]))
    else $error("system allocated bit not loaded");
  chk_pm_ctl_copy: assert property (
    s_pm1_word |=> pm_ctl[1] == $past(ld_data[5:0]))
    else $error("pm control field not loaded");
  chk_rx_pol_copy: assert property (
    s_pm1_word |=> rx_pol_dis[1] == $past(ld_data[6]))
    else $error("rx polarity bit not loaded");
  chk_vga_copy: assert property (
    s_pm1_word |=> vga_en[1] == $past(ld_data[7]))
    else $error("vga decode bit not loaded");
  chk_vendor_copy: assert property (
    s_pm1_word |=> vendor_five[1] == $past(ld_data[15:8]))
    else $error("vendor control byte not loaded");
  chk_apply_once: assert property (
    ld_valid && ld_addr == pcwl_pkg::WA_P3 && applied_r[0] && !reload
    |=> $stable(tc_map[3]) && $stable(port_num[3]))
    else $error("word applied twice");
  chk_hidden_read: assert property (
    s_early_cfg_read |=> reg_rdata == '0)
    else $error("config field exposed before load end");
  chk_read_slot_field: assert property (
    reg_rd && done_r && reg_addr == {1'b0, 2'h3, pcwl_pkg::OFF_SLOT}
    |=> reg_rdata[pcwl_pkg::D_SLOT] == $past(slot_impl[3]))
    else $error("slot bit misplaced on read");

  // Closing word of a load; words after it are refused
  sequence s_last_word;
    take && ld_last;
  endsequence

  chk_pb_route_zero: assert property (
    apply && ld_addr == pcwl_pkg::WA_PB0
    |=> pb_base[0] == $past(ld_data[7:0]) && $stable(pb_base[3]))
    else $error("first budget word reached wrong port");
  chk_done_on_last: assert property (
    s_last_word |=> load_done)
    else $error("load not closed by last word");
  chk_reload_reopen: assert property (
    reload && !take |=> !load_done && applied_r == '0)
    else $error("reload did not reopen loading");
  chk_refuse_closed: assert property (
    ld_valid && done_r
    |=> $stable(pb_base[0]) && $stable(pm_ctl[0]))
    else $error("word taken after load end");
  chk_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == '0)
    else $error("read data stood past its cycle");
endmodule // pcwl_loader
`default_nettype wire

// ===== sim/pcwl_store_model.sv
`default_nettype none
module pcwl_store_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Control from the bench
  input  wire logic        go,
  input  wire logic        slow,
  input  wire logic [15:0] base,
  // Word stream towards the loader
  output var logic         ld_valid,
  output var logic [7:0]   ld_addr,
  output var logic [15:0]  ld_data,
  output var logic         ld_last
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] idx_r;
  logic [1:0] gap_r;
  logic       run_r;

  // Store address of the i-th word
  function automatic logic [7:0] addr_of(input logic [2:0] i);
    case (i)
      3'h0: return 8'h66;
      3'h1: return 8'h70;
      3'h2: return 8'h72;
      3'h3: return 8'h74;
      3'h4: return 8'h76;
      3'h5: return 8'h80;
      default: return 8'h82;
    endcase
  endfunction

  // Idle lines flip every cycle so a stale value never looks valid
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      run_r    <= 1'b0;
      idx_r    <= 3'h0;
      gap_r    <= 2'h0;
      ld_valid <= 1'b0;
      ld_last  <= 1'b0;
      ld_addr  <= 8'h00;
      ld_data  <= 16'h0000;
    end else begin
      ld_valid <= 1'b0;
      ld_last  <= 1'b0;
      ld_addr  <= ~ld_addr;
      ld_data  <= ~ld_data;
      if (go && !run_r) begin
        run_r <= 1'b1;
        idx_r <= 3'h0;
        gap_r <= 2'h0;
      end else if (run_r && gap_r != 2'h0) begin
        gap_r <= gap_r - 2'h1;
      end else if (run_r) begin
        ld_valid <= 1'b1;
        ld_addr  <= addr_of(idx_r);
        ld_data  <= base ^ 16'(16'h1357 * idx_r);
        ld_last  <= (idx_r == 3'h6);
        idx_r    <= idx_r + 3'h1;
        gap_r    <= slow ? 2'h3 : 2'h0;
        if (idx_r == 3'h6) run_r <= 1'b0;
      end
    end
  end
endmodule // pcwl_store_model
`default_nettype wire

// ===== sim/tb_top.sv
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        sel = 1'b0, go = 1'b0, slow = 1'b0;
  logic [15:0] base = 16'h0000;
  logic        t_valid = 1'b0, t_last = 1'b0;
  logic [7:0]  t_addr = 8'h00;
  logic [15:0] t_data = 16'h0000;
  logic        m_valid, m_last;
  logic [7:0]  m_addr;
  logic [15:0] m_data;
  logic [12:0] reg_addr = 13'h0000;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0] reg_rdata, d;
  logic        load_done;
  logic [15:0] w3, wpb [4], wpm [2];
  int          miscompares = 0, samples_checked = 0;
  logic [9:0]  offs [11] = '{10'h0c0, 10'h0d0, 10'h040, 10'h144, 10'h0cc,
    10'h154, 10'h214, 10'h218, 10'h074, 10'h070, 10'h088};

  always #12.5 ref_clk = ~ref_clk;

  // Store lines come from the model or from the bench for odd words
  pcwl_store_model store (.ref_clk(ref_clk), .sys_rst(sys_rst), .go(go),
    .slow(slow), .base(base), .ld_valid(m_valid), .ld_addr(m_addr),
    .ld_data(m_data), .ld_last(m_last));
  pcwl_loader dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .ld_valid(sel ? m_valid : t_valid), .ld_addr(sel ? m_addr : t_addr),
    .ld_data(sel ? m_data : t_data), .ld_last(sel ? m_last : t_last),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .load_done(load_done));

  // Expected dword of one port and offset, from the words sent
  function automatic logic [31:0] exp_cfg(input int p, input logic [9:0] o);
    logic [31:0] e;
    e = 32'h0;
    if (p == 3 && o == 10'h0c0) e[24] = w3[0];
    if (p == 3 && o == 10'h0d0) e[28] = w3[1];
    if (p == 3 && o == 10'h040) e[21] = w3[2];
    if (p == 3 && o == 10'h144) e[4] = w3[3];
    if (p == 3 && o == 10'h0cc) e[26:24] = w3[6:4];
    if (p == 3 && o == 10'h154) e[7:1] = w3[15:9];
    if (o == 10'h214) e = {17'h0, wpb[p][11:10], 3'h0, wpb[p][9:0]};
    if (o == 10'h218) e[0] = wpb[p][15];
    if (p < 2 && o == 10'h074) e[14:8] = wpm[p][6:0];
    if (p < 2 && o == 10'h070) e[31] = wpm[p][7];
    if (p < 2 && o == 10'h088) e[31:24] = wpm[p][15:8];
    return e;
  endfunction

  task automatic reg_write(input logic [12:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [12:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic bench_word(input logic [7:0] a, input logic [15:0] v,
                            input logic l);
    @(posedge ref_clk);
    t_valid <= 1'b1; t_addr <= a; t_data <= v; t_last <= l;
    @(posedge ref_clk);
    t_valid <= 1'b0; t_addr <= ~a; t_data <= ~v; t_last <= 1'b0;
  endtask

  // Run the model once, then wait for the done level under a bound
  task automatic model_load(input logic [15:0] b, input logic s);
    @(posedge ref_clk);
    sel <= 1'b1; base <= b; slow <= s; go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    for (int i = 0; i < 60 && load_done !== 1'b1; i++) @(posedge ref_clk);
    `CHK(load_done, 1'b1)
    @(posedge ref_clk);
    sel <= 1'b0;
    for (int i = 0; i < 4; i++) wpb[i] = b ^ 16'(16'h1357 * (i + 1));
    for (int i = 0; i < 2; i++) wpm[i] = b ^ 16'(16'h1357 * (i + 5));
  endtask

  task automatic check_all();
    for (int p = 0; p < 4; p++)
      for (int k = 0; k < 11; k++) begin
        reg_read({1'b0, 2'(p), offs[k]}, d);
        `CHK(d, exp_cfg(p, offs[k]))
      end
  endtask

  task automatic t_reset();
    `CHK(load_done, 1'b0)
    reg_read(13'h1000, d);
    `CHK(d, 32'h0000_0000)
    reg_read(13'h0cc0, d);
    `CHK(d, 32'h0000_0000)
    #25 `CHK(reg_rdata, 32'h0000_0000)
    $display("test reset done");
  endtask

  // Repeat and unmapped words are ignored; fields stay hidden meanwhile
  task automatic t_first_load();
    w3 = 16'ha5c3;
    bench_word(8'h66, w3, 1'b0);
    bench_word(8'h66, 16'h5a3c, 1'b0);
    bench_word(8'h6a, 16'hffff, 1'b0);
    reg_read(13'h1000, d);
    `CHK(d, 32'h0001_0000)
    reg_read(13'h0cc0, d);
    `CHK(d, 32'h0000_0000)
    model_load(16'h9e61, 1'b0);
    check_all();
    reg_read(13'h1000, d);
    `CHK(d, 32'h007f_0001)
    bench_word(8'h70, 16'h7fff, 1'b1);
    reg_read(13'h0214, d);
    `CHK(d, exp_cfg(0, 10'h214))
    $display("test first load done");
  endtask

  // Reload clears status only; the model answers slowly this time
  task automatic t_reload();
    reg_write(13'h1000, 32'h0000_0001);
    reg_read(13'h1000, d);
    `CHK(d, 32'h007f_0001)
    reg_write(13'h1004, 32'h0000_0001);
    reg_read(13'h1000, d);
    `CHK(d, 32'h0000_0000)
    reg_read(13'h0cc0, d);
    `CHK(d, 32'h0000_0000)
    reg_read(13'h1004, d);
    `CHK(d, 32'h0000_0000)
    reg_read(13'h1008, d);
    `CHK(d, 32'h0000_0000)
    model_load(16'h36d8, 1'b1);
    w3 = 16'h36d8;
    check_all();
    $display("test reload done");
  endtask

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_first_load();
    t_reload();
    end_sim();
  end

  // Tests need well under two thousand cycles
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
